// >>> common/act_params.svh
// Purpose: constants of the counter array core
// Assumes: 32-bit AHB-Lite register words, byte offsets below
// Notes: included by bare name, guarded
//
// Overview of operation
// - 16-bit counter read as two bytes
// - low read latches high byte snapshot
// - reads never disturb counting
// - three-bit select picks count tick source
// - oscillator/8 tick synchronised before use
// - wrap ffff to 0 sets main flag
// - main flag interrupts only when enabled
// - flags stay set; software clears them
// - idle halt clear: counts during idle
// - partial flag on bit 8-11 carry
// - three channels, pins, one flag each
// - flags set regardless of enables
// - request is OR of enabled flags
// - cpu sees it with both global enables
// - channel 2 watchdog after reset, restricted
// - two-bit length picks partial wrap bit
`ifndef ACT_PARAMS_SVH
`define ACT_PARAMS_SVH
// ************************************
// register byte offsets
// ************************************
`define ACT_OFF_CNT_LO 8'h00
`define ACT_OFF_CNT_HI 8'h04
`define ACT_OFF_MODE 8'h08
`define ACT_OFF_FLAGS 8'h0C
`define ACT_OFF_IRQEN 8'h10
`define ACT_OFF_CH_BASE 8'h14
`define ACT_CH_STRIDE 8'h08
`define ACT_CH_MODE_OFS 8'h04
// ************************************
// mode register fields
// ************************************
`define ACT_MODE_ECF 0
`define ACT_MODE_TB_LSB 1
`define ACT_MODE_WDT 6
`define ACT_MODE_IDLE_HALT_SELECT 7
`define ACT_MODE_RST 8'h40
// ************************************
// flags and enables fields
// ************************************
`define ACT_FLG_MAIN 0
`define ACT_FLG_PART 1
`define ACT_FLG_CH_LSB 2
`define ACT_EN_PART 0
`define ACT_EN_CH_LSB 1
`define ACT_EN_LEN_LSB 4
`define ACT_EN_ARRAY 6
`define ACT_EN_GLOBAL 7
`define ACT_IRQEN_RST 8'h00
// ************************************
// channel mode fields
// ************************************
`define ACT_CHM_CAPP 0
`define ACT_CHM_CAPN 1
`define ACT_CHM_MAT 2
`define ACT_WDT_CH 2
// ************************************
// timebase prescale counts
// ************************************
`define ACT_DIV_SLOW 4'd11
`define ACT_DIV_FAST 2'd3
`endif

// >>> common/act_pkg.sv
// Purpose: shared types of the counter array core
// Assumes: nothing
// Notes: codes of the timebase select
package act_pkg;
  typedef enum logic [2:0] {
    ACT_TB_DIV12 = 3'h0,
    ACT_TB_DIV4 = 3'h1,
    ACT_TB_T0 = 3'h2,
    ACT_TB_ECI = 3'h3,
    ACT_TB_SYS = 3'h4,
    ACT_TB_OSC8 = 3'h5,
    ACT_TB_RES6 = 3'h6,
    ACT_TB_RES7 = 3'h7
  } act_tb_t;
  typedef logic [7:0] act_byte_t;
endpackage

// >>> rtl/act_timebase.sv
// Purpose: count tick generator for the array counter
// Assumes: pin inputs asynchronous, timer-0 overflow on hclk
// Notes: tick is a registered pulse, held high every cycle on the system clock code
`timescale 1ns/100ps
`include "act_params.svh"
module act_timebase (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [2:0] sel,
  input wire logic t0_overflow,
  input wire logic external_count_input,
  input wire logic ext_osc_div8,
  output logic tick_q
);
  logic [1:0] eci_sync_q;
  logic eci_last_q;
  logic [1:0] osc_sync_q;
  logic osc_last_q;
  logic [3:0] div12_q;
  logic [1:0] div4_q;
  logic tick_d;

  // ************************************
  // synchronisers and edge detect
  // ************************************
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      eci_sync_q <= 2'h3;
      eci_last_q <= 1'b1;
      osc_sync_q <= 2'h0;
      osc_last_q <= 1'b0;
    end
    else
    begin
      eci_sync_q <= {eci_sync_q[0], external_count_input};
      eci_last_q <= eci_sync_q[1];
      osc_sync_q <= {osc_sync_q[0], ext_osc_div8};
      osc_last_q <= osc_sync_q[1];
    end

  // ************************************
  // prescalers
  // ************************************
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      div12_q <= 4'h0;
      div4_q <= 2'h0;
    end
    else
    begin
      div12_q <= (div12_q == `ACT_DIV_SLOW) ? 4'h0 : div12_q + 4'h1;
      div4_q <= div4_q + 2'h1;
    end

  // edges faster than clock/4 may merge in the synchroniser
  always_comb
  begin
    case (act_pkg::act_tb_t'(sel))
      act_pkg::ACT_TB_DIV12: tick_d = (div12_q == `ACT_DIV_SLOW);
      act_pkg::ACT_TB_DIV4: tick_d = (div4_q == `ACT_DIV_FAST);
      act_pkg::ACT_TB_T0: tick_d = t0_overflow;
      act_pkg::ACT_TB_ECI: tick_d = eci_last_q & ~eci_sync_q[1];
      act_pkg::ACT_TB_SYS: tick_d = 1'b1;
      act_pkg::ACT_TB_OSC8: tick_d = osc_sync_q[1] & ~osc_last_q;
      default: tick_d = 1'b0;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      tick_q <= 1'b0;
    else
      tick_q <= tick_d;
endmodule

// >>> rtl/act_channel.sv
// Purpose: one capture/compare channel, flag trigger only
// Assumes: count and count_adv on hclk, pin asynchronous
// Notes: software write of the compare word wins over a capture
`timescale 1ns/100ps
`include "act_params.svh"
module act_channel (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [15:0] count,
  input wire logic count_adv,
  input wire logic wr_cmp,
  input wire logic wr_mode,
  input wire logic [15:0] wdata,
  input wire logic channel_pin,
  output logic [15:0] cmp_q,
  output logic [2:0] mode_q,
  output logic event_q
);
  logic [1:0] pin_sync_q;
  logic pin_last_q;
  logic rise;
  logic fall;
  logic capture;

  assign rise = pin_sync_q[1] & ~pin_last_q;
  assign fall = ~pin_sync_q[1] & pin_last_q;
  assign capture = (rise & mode_q[`ACT_CHM_CAPP]) | (fall & mode_q[`ACT_CHM_CAPN]);

  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      pin_sync_q <= 2'h0;
      pin_last_q <= 1'b0;
    end
    else
    begin
      pin_sync_q <= {pin_sync_q[0], channel_pin};
      pin_last_q <= pin_sync_q[1];
    end

  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      cmp_q <= 16'h0000;
      mode_q <= 3'h0;
    end
    else
    begin
      if (wr_cmp)
        cmp_q <= wdata;
      else if (capture)
        cmp_q <= count;
      if (wr_mode)
        mode_q <= wdata[2:0];
    end

  // match looks at the freshly advanced count only
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      event_q <= 1'b0;
    else
      event_q <= capture | (count_adv & mode_q[`ACT_CHM_MAT] & (count == cmp_q));
endmodule

// >>> rtl/act_core.sv
// Purpose: counter array core with AHB-Lite register slave
// Assumes: single master, zero wait states, word accesses
// Notes: interrupt request and watchdog reset are registered pulses/levels
//
// Decided for this implementation: the AHB-Lite register port and the address map.
`timescale 1ns/100ps
`include "act_params.svh"
module act_core #(
  parameter int NUM_CH = 3
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic cpu_idle,
  input wire logic t0_overflow,
  input wire logic external_count_input,
  input wire logic ext_osc_div8,
  input wire logic [NUM_CH-1:0] channel_pin,
  output logic array_irq_q,
  output logic cpu_irq_q,
  output logic wdt_reset_q
);
  logic [15:0] cnt_q;
  logic [7:0] snap_q;
  logic [7:0] mode_q;
  logic [7:0] irqen_q;
  logic [NUM_CH+1:0] flags_q;
  logic [31:0] hrdata_q;
  logic wr_pend_q;
  logic [7:0] wr_addr_q;
  logic adv_q;
  logic tick;
  logic adv;
  logic take;
  logic rd_take;
  logic [7:0] rd_addr;
  logic [31:0] rd_val;
  logic wr_now;
  logic [NUM_CH+1:0] set_evt;
  logic [NUM_CH+1:0] clr_evt;
  logic [NUM_CH+1:0] enables;
  logic [NUM_CH-1:0] ch_evt;
  logic [15:0] ch_cmp [NUM_CH];
  logic [2:0] ch_mode [NUM_CH];
  logic wdt_on;

  // ************************************
  // helpers
  // ************************************
  function automatic logic is_off(input logic [7:0] a, input logic [7:0] off);
    is_off = (a == off);
  endfunction

  // all ones below and including bit (7 + len) means a carry out of it
  function automatic logic part_wrap(input logic [15:0] c, input logic [1:0] len);
    logic [15:0] mask;
    mask = 16'((17'h00100 << len) - 17'h00001);
    part_wrap = ((c & mask) == mask);
  endfunction

  // ************************************
  // AHB-Lite slave
  // ************************************
  assign take = hsel & htrans[1] & hready;
  assign rd_take = take & ~hwrite;
  assign rd_addr = haddr[7:0];
  assign wr_now = wr_pend_q;
  assign wdt_on = mode_q[`ACT_MODE_WDT];

  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
    end
    else
    begin
      wr_pend_q <= take & hwrite;
      wr_addr_q <= haddr[7:0];
    end

  always_comb
  begin
    rd_val = 32'h0000_0000;
    if (is_off(rd_addr, `ACT_OFF_CNT_LO))
      rd_val[7:0] = cnt_q[7:0];
    else if (is_off(rd_addr, `ACT_OFF_CNT_HI))
      rd_val[7:0] = snap_q;
    else if (is_off(rd_addr, `ACT_OFF_MODE))
      rd_val[7:0] = mode_q;
    else if (is_off(rd_addr, `ACT_OFF_FLAGS))
      rd_val[NUM_CH+1:0] = flags_q;
    else if (is_off(rd_addr, `ACT_OFF_IRQEN))
      rd_val[7:0] = irqen_q;
    for (int i = 0; i < NUM_CH; i++)
    begin
      if (is_off(rd_addr, 8'(`ACT_OFF_CH_BASE + i * `ACT_CH_STRIDE)))
        rd_val[15:0] = ch_cmp[i];
      if (is_off(rd_addr, 8'(`ACT_OFF_CH_BASE + i * `ACT_CH_STRIDE + `ACT_CH_MODE_OFS)))
        rd_val[2:0] = ch_mode[i];
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      hrdata_q <= 32'h0000_0000;
    else if (rd_take)
      hrdata_q <= rd_val;

  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end

  assign hrdata = hrdata_q;

  // ************************************
  // snapshot of the high byte
  // ************************************
  // a high read without a low read first may show a stale byte
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      snap_q <= 8'h00;
    else if (rd_take && is_off(rd_addr, `ACT_OFF_CNT_LO))
      snap_q <= cnt_q[15:8];

  // ************************************
  // timebase and counter
  // ************************************
  act_timebase u_timebase (
    .hclk(hclk),
    .hresetn(hresetn),
    .sel(mode_q[`ACT_MODE_TB_LSB +: 3]),
    .t0_overflow(t0_overflow),
    .external_count_input(external_count_input),
    .ext_osc_div8(ext_osc_div8),
    .tick_q(tick)
  );

  // idle stalls the count only with the halt select set
  assign adv = tick & ~(cpu_idle & mode_q[`ACT_MODE_IDLE_HALT_SELECT]);

  // a software write to a count byte wins over a tick in the same cycle, but is dropped while the watchdog runs
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      cnt_q <= 16'h0000;
    else if (wr_now && !wdt_on && is_off(wr_addr_q, `ACT_OFF_CNT_LO))
      cnt_q[7:0] <= hwdata[7:0];
    else if (wr_now && !wdt_on && is_off(wr_addr_q, `ACT_OFF_CNT_HI))
      cnt_q[15:8] <= hwdata[7:0];
    else if (adv)
      cnt_q <= cnt_q + 16'h0001;

  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      adv_q <= 1'b0;
    else
      adv_q <= adv;

  // ************************************
  // mode and enable registers
  // ************************************
  // while the watchdog runs only its own enable bit of the mode register may be written
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      mode_q <= `ACT_MODE_RST;
    else if (wr_now && is_off(wr_addr_q, `ACT_OFF_MODE))
    begin
      if (wdt_on)
        mode_q[`ACT_MODE_WDT] <= hwdata[`ACT_MODE_WDT];
      else
        mode_q <= hwdata[7:0];
    end

  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      irqen_q <= `ACT_IRQEN_RST;
    else if (wr_now && is_off(wr_addr_q, `ACT_OFF_IRQEN))
      irqen_q <= hwdata[7:0];

  // ************************************
  // capture/compare channels
  // ************************************
  for (genvar g = 0; g < NUM_CH; g++)
  begin : g_ch
    logic wr_ok;
    assign wr_ok = wr_now && !(wdt_on && g == `ACT_WDT_CH);
    act_channel u_channel (
      .hclk(hclk),
      .hresetn(hresetn),
      .count(cnt_q),
      .count_adv(adv_q),
      .wr_cmp(wr_ok && is_off(wr_addr_q, 8'(`ACT_OFF_CH_BASE + g * `ACT_CH_STRIDE))),
      .wr_mode(wr_ok && is_off(wr_addr_q,
        8'(`ACT_OFF_CH_BASE + g * `ACT_CH_STRIDE + `ACT_CH_MODE_OFS))),
      .wdata(hwdata[15:0]),
      .channel_pin(channel_pin[g]),
      .cmp_q(ch_cmp[g]),
      .mode_q(ch_mode[g]),
      .event_q(ch_evt[g])
    );
  end

  // ************************************
  // event flags
  // ************************************
  always_comb
  begin
    set_evt = '0;
    set_evt[`ACT_FLG_MAIN] = adv && (cnt_q == 16'hFFFF);
    set_evt[`ACT_FLG_PART] = adv && part_wrap(cnt_q, irqen_q[`ACT_EN_LEN_LSB +: 2]);
    set_evt[`ACT_FLG_CH_LSB +: NUM_CH] = ch_evt;
  end

  assign clr_evt = (wr_now && is_off(wr_addr_q, `ACT_OFF_FLAGS)) ?
    ~hwdata[NUM_CH+1:0] : '0;

  // no hardware clear: flags stay up through interrupt entry
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      flags_q <= '0;
    else
      flags_q <= (flags_q & ~clr_evt) | set_evt;

  // ************************************
  // interrupt request
  // ************************************
  assign enables = {irqen_q[`ACT_EN_CH_LSB +: NUM_CH], irqen_q[`ACT_EN_PART],
    mode_q[`ACT_MODE_ECF]};

  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      array_irq_q <= 1'b0;
      cpu_irq_q <= 1'b0;
    end
    else
    begin
      array_irq_q <= |(flags_q & enables);
      cpu_irq_q <= |(flags_q & enables) && irqen_q[`ACT_EN_GLOBAL]
        && irqen_q[`ACT_EN_ARRAY];
    end

  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      wdt_reset_q <= 1'b0;
    else
      wdt_reset_q <= wdt_on && ch_evt[`ACT_WDT_CH];

  // ************************************
  // assertions
  // ************************************
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  property p_snap_take;
    rd_take && is_off(rd_addr, `ACT_OFF_CNT_LO) |=> snap_q == $past(cnt_q[15:8]);
  endproperty
  a_snap_take: assert property (p_snap_take) else $error("snapshot not taken");

  property p_high_read;
    rd_take && is_off(rd_addr, `ACT_OFF_CNT_HI) |=> hrdata[7:0] == $past(snap_q);
  endproperty
  a_high_read: assert property (p_high_read) else $error("high read not snapshot");

  property p_read_counts;
    rd_take && adv && !wr_now |=> cnt_q == 16'($past(cnt_q) + 16'h0001);
  endproperty
  a_read_counts: assert property (p_read_counts) else $error("read disturbed count");

  property p_wrap;
    adv && cnt_q == 16'hFFFF && !wr_now |=> cnt_q == 16'h0000 && flags_q[`ACT_FLG_MAIN];
  endproperty
  a_wrap: assert property (p_wrap) else $error("wrap flag missing");

  property p_set_wins;
    set_evt[`ACT_FLG_MAIN] && clr_evt[`ACT_FLG_MAIN] |=> flags_q[`ACT_FLG_MAIN];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("clear beat set");

  property p_main_masked;
    !mode_q[`ACT_MODE_ECF] && flags_q == 5'b00001 |=> !array_irq_q;
  endproperty
  a_main_masked: assert property (p_main_masked) else $error("masked flag interrupts");

  property p_cpu_irq;
    cpu_irq_q |-> array_irq_q && $past(irqen_q[`ACT_EN_GLOBAL]) && $past(irqen_q[`ACT_EN_ARRAY]);
  endproperty
  a_cpu_irq: assert property (p_cpu_irq) else $error("cpu irq without enables");

  property p_idle_hold;
    cpu_idle && mode_q[`ACT_MODE_IDLE_HALT_SELECT] && !wr_now |=> $stable(cnt_q);
  endproperty
  a_idle_hold: assert property (p_idle_hold) else $error("count moved in idle");

  property p_reserved;
    mode_q[`ACT_MODE_TB_LSB + 2 -: 2] == 2'h3 [*2] ##0 !wr_now |=> $stable(cnt_q);
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved timebase ticked");

  property p_wdt_reset;
    $rose(hresetn) |-> wdt_on;
  endproperty
  a_wdt_reset: assert property (@(posedge hclk) p_wdt_reset) else $error("watchdog off at reset");

  c_wrap: cover property (set_evt[`ACT_FLG_MAIN]);
  c_cpu_irq: cover property (cpu_irq_q);
  c_coherent: cover property (rd_take && is_off(rd_addr, `ACT_OFF_CNT_LO) ##2
    rd_take && is_off(rd_addr, `ACT_OFF_CNT_HI));
endmodule

// >>> bench/act_core_tb.sv
// Purpose: self-checking bench of the counter array core
// Assumes: zero wait state slave answers, seed starts at 28
// Notes: counting windows opened and closed by mode writes
`timescale 1ns/100ps
`include "act_params.svh"
module act_core_tb;
  localparam logic [7:0] o_lo = `ACT_OFF_CNT_LO;
  localparam logic [7:0] o_hi = `ACT_OFF_CNT_HI;
  localparam logic [7:0] o_md = `ACT_OFF_MODE;
  localparam logic [7:0] o_fl = `ACT_OFF_FLAGS;
  localparam logic [7:0] o_en = `ACT_OFF_IRQEN;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  logic cpu_idle = 1'b0;
  logic t0_overflow = 1'b0;
  logic external_count_input = 1'b1;
  logic ext_osc_div8 = 1'b0;
  logic [2:0] channel_pin = 3'h0;
  logic array_irq_q;
  logic cpu_irq_q;
  logic wdt_reset_q;
  integer seed = 28;
  int errors = 0;
  int n_tests = 0;
  int cycles = 0;
  int n_wdt = 0;
  int n_t0;
  int n_fall;
  int n_osc;
  int e;
  logic r;
  logic [31:0] rd;
  logic [31:0] a;
  logic [31:0] b;
  logic [31:0] cnt;

  act_core dut_u (
    .hclk(hclk),
    .hresetn(hresetn),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(3'h2),
    .hwdata(hwdata),
    .hready(hreadyout),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .hrdata(hrdata),
    .cpu_idle(cpu_idle),
    .t0_overflow(t0_overflow),
    .external_count_input(external_count_input),
    .ext_osc_div8(ext_osc_div8),
    .channel_pin(channel_pin),
    .array_irq_q(array_irq_q),
    .cpu_irq_q(cpu_irq_q),
    .wdt_reset_q(wdt_reset_q)
  );

  always #5 hclk = ~hclk;

  // one-cycle pulse, counted mid-cycle where it has settled
  always @(negedge hclk)
    n_wdt += wdt_reset_q;

  // hang guard, well above the expected run length
  always @(posedge hclk)
  begin
    cycles++;
    if (cycles == 30000)
    begin
      errors++;
      results();
    end
  end

  // ************************************
  // checks and bus cycles
  // ************************************
  task automatic results();
    if (errors == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
    n_tests++;
    if ((got >= lo && got <= hi) !== 1'b1)
    begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, lo);
    end
  endtask

  task automatic bus(input logic wr, input logic [7:0] ad, input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {24'h0, ad};
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wd;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask

  task automatic wr_reg(input logic [7:0] ad, input logic [31:0] wd);
    bus(1'b1, ad, wd);
  endtask

  task automatic rd_reg(input logic [7:0] ad);
    bus(1'b0, ad, 32'h0);
  endtask

  // count from v with the system clock tick, then freeze on a reserved code
  task automatic pre(input logic [15:0] v);
    wr_reg(o_hi, {24'h0, v[15:8]});
    wr_reg(o_lo, {24'h0, v[7:0]});
    wr_reg(o_md, 32'h08);
    repeat (20) @(posedge hclk);
    wr_reg(o_md, 32'h0C);
  endtask

  // window of w cycles under mode md; pin events are counted as they are driven
  task automatic run(input logic [7:0] md, input int w, input logic idle, input logic rds);
    wr_reg(o_lo, 32'h0);
    wr_reg(o_hi, 32'h0);
    n_t0 = 0;
    n_fall = 0;
    n_osc = 0;
    cpu_idle <= idle;
    wr_reg(o_md, {24'h0, md});
    for (int i = 0; i < w; i++)
    begin
      r = $random(seed);
      t0_overflow <= r;
      n_t0 += r;
      if (i % 4 == 0)
      begin
        // falling edge every 8 cycles, under the clock/4 ceiling
        n_fall += external_count_input;
        external_count_input <= ~external_count_input;
      end
      if (i % 3 == 0)
      begin
        n_osc += !ext_osc_div8;
        ext_osc_div8 <= ~ext_osc_div8;
      end
      if (rds)
      begin
        rd_reg(o_lo);
        i++;
      end
      else
        @(posedge hclk);
    end
    t0_overflow <= 1'b0;
    wr_reg(o_md, 32'h0C);
    cpu_idle <= 1'b0;
    rd_reg(o_lo);
    b = rd;
    rd_reg(o_hi);
    cnt = {16'h0, rd[7:0], b[7:0]};
  endtask

  function automatic int expect_ticks(input int code, input int w);
    case (code)
      0: return (w + 2) / 12;
      1: return (w + 2) / 4;
      2: return n_t0;
      3: return n_fall;
      4: return w + 2;
      5: return n_osc;
      default: return 0;
    endcase
  endfunction

  // ************************************
  // main sequence
  // ************************************
  initial
  begin
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd_reg(o_md);
    chk(rd, 32'h40, 32'h40);
    rd_reg(o_en);
    chk(rd, 32'h0, 32'h0);
    rd_reg(8'hFC);
    chk(rd, 32'h0, 32'h0);
    wr_reg(o_lo, 32'hAA);
    rd_reg(o_lo);
    chk(rd, 32'h0, 32'h0F);
    wr_reg(o_md, 32'h4D);
    rd_reg(o_md);
    chk(rd, 32'h40, 32'h40);
    wr_reg(o_md, 32'h0C);
    wr_reg(o_md, 32'h0C);
    rd_reg(o_md);
    chk(rd, 32'h0C, 32'h0C);
    for (int k = 0; k < 8; k++)
    begin
      a = (k == 0) ? 32'hFF : $random(seed) & 32'hFF;
      b = (k == 0) ? 32'hFF : $random(seed) & 32'hFF;
      wr_reg(o_hi, b);
      wr_reg(o_lo, a);
      repeat (5) @(posedge hclk);
      rd_reg(o_lo);
      chk(rd, a, a);
      rd_reg(o_hi);
      chk(rd, b, b);
      chk(hresp, 32'h0, 32'h0);
    end
    wr_reg(o_hi, 32'h12);
    wr_reg(o_lo, 32'hF0);
    wr_reg(o_md, 32'h08);
    rd_reg(o_lo);
    chk(rd, 32'hF0, 32'hFF);
    repeat (40) @(posedge hclk);
    rd_reg(o_hi);
    chk(rd, 32'h12, 32'h12);
    wr_reg(o_md, 32'h0C);
    rd_reg(o_lo);
    rd_reg(o_hi);
    chk(rd, 32'h13, 32'h13);
    for (int c = 0; c < 8; c++)
    begin
      run({4'h0, c[2:0], 1'b0}, 600, 1'b0, 1'b0);
      e = expect_ticks(c, 600);
      if (c < 6)
        chk(cnt, e - 2, e + 2);
      else
        chk(cnt, 32'h0, 32'h0);
    end
    run(8'h08, 40, 1'b0, 1'b0);
    a = cnt;
    chk(a, 32'd40, 32'd44);
    run(8'h08, 40, 1'b0, 1'b1);
    chk(cnt, a, a);
    run(8'h88, 100, 1'b1, 1'b0);
    chk(cnt, 32'h0, 32'h0);
    run(8'h08, 100, 1'b1, 1'b0);
    chk(cnt, 32'd100, 32'd104);
    run(8'h88, 100, 1'b0, 1'b0);
    chk(cnt, 32'd100, 32'd104);
    // ************************************
    // flags and interrupt tree
    // ************************************
    pre(16'hFFF0);
    rd_reg(o_fl);
    chk(rd, 32'h03, 32'h03);
    chk(array_irq_q, 32'h0, 32'h0);
    wr_reg(o_md, 32'h0D);
    repeat (3) @(posedge hclk);
    chk(array_irq_q, 32'h1, 32'h1);
    chk(cpu_irq_q, 32'h0, 32'h0);
    wr_reg(o_en, 32'h40);
    repeat (3) @(posedge hclk);
    chk(cpu_irq_q, 32'h0, 32'h0);
    wr_reg(o_en, 32'hC0);
    repeat (3) @(posedge hclk);
    chk(cpu_irq_q, 32'h1, 32'h1);
    rd_reg(o_fl);
    chk(rd, 32'h03, 32'h03);
    wr_reg(o_fl, 32'h1E);
    rd_reg(o_fl);
    chk(rd, 32'h02, 32'h02);
    repeat (2) @(posedge hclk);
    chk(array_irq_q, 32'h0, 32'h0);
    wr_reg(o_en, 32'hC1);
    repeat (3) @(posedge hclk);
    chk(cpu_irq_q, 32'h1, 32'h1);
    wr_reg(o_fl, 32'h0);
    wr_reg(o_md, 32'h0C);
    for (int l = 0; l < 4; l++)
    begin
      wr_reg(o_en, {26'h0, l[1:0], 4'h0});
      pre(16'(32'h1 << (7 + l)) - 16'd10);
      rd_reg(o_fl);
      chk(rd & 32'h2, 32'h0, 32'h0);
      pre(16'(32'h1 << (8 + l)) - 16'd10);
      rd_reg(o_fl);
      chk(rd & 32'h2, 32'h2, 32'h2);
      wr_reg(o_fl, 32'h0);
    end
    wr_reg(o_hi, 32'h0A);
    wr_reg(o_lo, 32'hBC);
    wr_reg(o_en, 32'hC0);
    for (int n = 0; n < 3; n++)
    begin
      wr_reg(`ACT_OFF_CH_BASE + `ACT_CH_MODE_OFS + 8'(8 * n), 32'h1);
      channel_pin[n] <= 1'b1;
      repeat (6) @(posedge hclk);
      rd_reg(`ACT_OFF_CH_BASE + 8'(8 * n));
      chk(rd, 32'hABC, 32'hABC);
      rd_reg(o_fl);
      chk(rd, 32'h4 << n, 32'h4 << n);
      chk(cpu_irq_q, 32'h0, 32'h0);
      wr_reg(o_en, 32'hC0 | (32'h2 << n));
      repeat (3) @(posedge hclk);
      chk(cpu_irq_q, 32'h1, 32'h1);
      wr_reg(o_fl, 32'h0);
      wr_reg(o_en, 32'hC0);
    end
    // channel 2 match while the watchdog runs gives one reset pulse
    chk(n_wdt, 32'h0, 32'h0);
    wr_reg(`ACT_OFF_CH_BASE + 8'h10, 32'hAC0);
    wr_reg(`ACT_OFF_CH_BASE + `ACT_CH_MODE_OFS + 8'h10, 32'h4);
    wr_reg(o_md, 32'h48);
    repeat (20) @(posedge hclk);
    wr_reg(o_md, 32'h0C);
    wr_reg(o_md, 32'h0C);
    rd_reg(o_fl);
    chk(rd, 32'h10, 32'h10);
    chk(n_wdt, 32'h1, 32'h1);
    results();
  end
endmodule
